// ===== design/lsir_core.sv
// Line status, interrupt event and error counter registers.
// Assumes detector inputs and host strobes synchronous to clock.
//
// Behaviour
// RQ1 - Status bit 2 follows driver short circuit
// RQ2 - Edge select 0: event on rising status
// RQ3 - Edge select 1: event on any change
// RQ4 - Status bit 1 follows AIS detection
// RQ5 - Status bit 0 follows signal loss
// RQ6 - Second status bit 5 shows remote loopback
// RQ7 - First status register is live, read only
// RQ8 - Second status register live, reserved bits zero
// RQ9 - Reading first event register clears it
// RQ10 - Reading second event register clears it
// RQ11 - First event register bit layout
// RQ12 - Second event register upper bit layout
// RQ13 - Second event register lower bit layout
// RQ14 - Low counter byte at 1BH, reset zero
// RQ15 - High counter byte at 1CH, reset zero
// RQ16 - Clock loss after over 70 idle cycles
// RQ17 - Pattern sync status follows pattern detector
// RQ18 - Events latch until read; masked sources blocked
// RQ19 - Request out while unmasked event pending
`include "lsir_params.svh"

module lsir_core
  import lsir_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire lsir_pkg::lsir_byte_t reg_addr,
  input  wire logic             reg_rd,
  output lsir_pkg::lsir_byte_t  reg_rdata,
  input  wire logic             driver_short_detect,
  input  wire logic             ais_detect,
  input  wire logic             los_detect,
  input  wire logic             remote_loopback_active,
  input  wire logic             pattern_sync_detect,
  input  wire logic             loopback_activate_detect,
  input  wire logic             loopback_deactivate_detect,
  input  wire logic             tx_line_clock,
  input  wire logic             waveform_amp_overflow,
  input  wire logic             jitter_buf_overflow,
  input  wire logic             jitter_buf_underflow,
  input  wire logic             pattern_error,
  input  wire logic             excess_zeros,
  input  wire logic             code_violation,
  input  wire logic             one_second_timer,
  input  wire logic             err_inc,
  input  wire lsir_pkg::lsir_src_t  status_mask,
  input  wire lsir_pkg::lsir_src_t  status_edge_sel,
  input  wire lsir_pkg::lsir_byte_t event_mask_b,
  output logic                  irq
);

  lsir_mon_if mon ();

  lsir_core_s q;
  lsir_core_s d;

  logic       driver_fault_status;
  logic       alarm_indication_status;
  logic       signal_loss_status;
  logic       remote_loopback_status;
  logic       pattern_sync_status;
  logic       tx_clock_loss_status;
  lsir_byte_t stat_a;
  lsir_byte_t stat_b;
  lsir_byte_t src_b;
  lsir_byte_t cond_a;
  lsir_byte_t cond_b;
  logic       clr_a;
  logic       clr_b;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  lsir_tx_line_clock_mon u_tmon (
    .clock         (clock),
    .srst          (srst),
    .tx_line_clock (tx_line_clock),
    .mon           (mon.tmon)
  );

  lsir_err_cnt u_cnt (
    .clock   (clock),
    .srst    (srst),
    .err_inc (err_inc),
    .mon     (mon.cnt)
  );

  // ----------------------------------------------------------------
  // Live status
  // ----------------------------------------------------------------
  assign driver_fault_status     = driver_short_detect; // RQ1
  assign alarm_indication_status = ais_detect; // RQ4
  assign signal_loss_status      = los_detect; // RQ5
  assign remote_loopback_status  = remote_loopback_active; // RQ6
  assign pattern_sync_status     = pattern_sync_detect; // RQ17
  assign tx_clock_loss_status    = mon.tx_line_clock_loss; // RQ16

  // RQ7
  assign stat_a = {1'b0,
                   loopback_activate_detect,
                   loopback_deactivate_detect,
                   pattern_sync_status,
                   tx_clock_loss_status,
                   driver_fault_status,
                   alarm_indication_status,
                   signal_loss_status};

  // RQ8
  assign stat_b = {2'b00, remote_loopback_status, 5'b00000};

  // ----------------------------------------------------------------
  // Event conditions
  // ----------------------------------------------------------------
  assign cond_a[7] = 1'b0;

  for (genvar i = 0; i < 7; i++) begin : g_src
    always_comb begin
      if (status_mask[i]) begin
        cond_a[i] = 1'b0; // RQ18
      end else if (status_edge_sel[i]) begin
        cond_a[i] = stat_a[i] ^ q.prev[i]; // RQ3
      end else begin
        cond_a[i] = stat_a[i] & ~q.prev[i]; // RQ2
      end
    end
  end

  // RQ12 RQ13
  assign src_b = {waveform_amp_overflow,
                  jitter_buf_overflow,
                  jitter_buf_underflow,
                  pattern_error,
                  excess_zeros,
                  code_violation,
                  one_second_timer,
                  mon.cnt_ovf};

  assign cond_b = src_b & ~event_mask_b; // RQ18

  assign clr_a = reg_rd && (reg_addr == `LSIR_ADDR_EVT_A);
  assign clr_b = reg_rd && (reg_addr == `LSIR_ADDR_EVT_B);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d      = q;
    d.prev = stat_a[6:0];
    // New events win over a clearing read in the same cycle
    d.ev_a = (clr_a ? `LSIR_RST_BYTE : q.ev_a) | cond_a; // RQ9 RQ11
    d.ev_b = (clr_b ? `LSIR_RST_BYTE : q.ev_b) | cond_b; // RQ10
    if (reg_rd) begin
      if (reg_addr == `LSIR_ADDR_STAT_A) begin
        d.rdata = stat_a; // RQ7
      end else if (reg_addr == `LSIR_ADDR_STAT_B) begin
        d.rdata = stat_b; // RQ8
      end else if (reg_addr == `LSIR_ADDR_EVT_A) begin
        d.rdata = q.ev_a;
      end else if (reg_addr == `LSIR_ADDR_EVT_B) begin
        d.rdata = q.ev_b;
      end else if (reg_addr == `LSIR_ADDR_CNT_LOW) begin
        d.rdata = mon.err_count[7:0]; // RQ14
      end else if (reg_addr == `LSIR_ADDR_CNT_HIGH) begin
        d.rdata = mon.err_count[15:8]; // RQ15
      end else begin
        d.rdata = `LSIR_RST_BYTE;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q.prev  <= 7'h00;
      q.ev_a  <= `LSIR_RST_BYTE;
      q.ev_b  <= `LSIR_RST_BYTE;
      q.rdata <= `LSIR_RST_BYTE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = q.rdata;
  assign irq = (|(q.ev_a[6:0] & ~status_mask))
             | (|(q.ev_b & ~event_mask_b)); // RQ19

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  rise_event_a: assert property (@(posedge clock) disable iff (srst) // RQ2
    (!status_mask[0] && !status_edge_sel[0] && los_detect && !q.prev[0])
    |=> q.ev_a[`LSIR_BIT_LOS])
    else $error("rising loss gave no event");

  fall_no_event_a: assert property (@(posedge clock) disable iff (srst) // RQ2
    (!status_edge_sel[1] && !ais_detect && !q.ev_a[1])
    |=> !q.ev_a[`LSIR_BIT_AIS])
    else $error("event set without rising edge");

  any_edge_a: assert property (@(posedge clock) disable iff (srst) // RQ3
    (!status_mask[1] && status_edge_sel[1] && !ais_detect && q.prev[1])
    |=> q.ev_a[`LSIR_BIT_AIS])
    else $error("falling change gave no event");

  mask_block_a: assert property (@(posedge clock) disable iff (srst) // RQ18
    (status_mask[2] && !q.ev_a[2]) |=> !q.ev_a[`LSIR_BIT_DF])
    else $error("masked source set its event");

  clear_a_read_a: assert property (@(posedge clock) disable iff (srst) // RQ9
    (clr_a && cond_a == 8'h00) |=> (q.ev_a == 8'h00 && reg_rdata ==
    $past(q.ev_a)))
    else $error("first event register not cleared by read");

  clear_b_read_a: assert property (@(posedge clock) disable iff (srst) // RQ10
    (clr_b && cond_b == 8'h00) |=> (q.ev_b == 8'h00 && reg_rdata ==
    $past(q.ev_b)))
    else $error("second event register not cleared by read");

  code_event_a: assert property (@(posedge clock) disable iff (srst) // RQ13
    (code_violation && !event_mask_b[2])
    |=> q.ev_b[2] ##1 (q.ev_b[2] || $past(clr_b)))
    else $error("code violation event lost");

  live_stat_a: assert property (@(posedge clock) disable iff (srst) // RQ7
    (reg_rd && reg_addr == `LSIR_ADDR_STAT_A)
    |=> reg_rdata == {1'b0, $past(stat_a[6:0])})
    else $error("live status read mismatch");

  stat_b_rsv_a: assert property (@(posedge clock) disable iff (srst) // RQ8
    (reg_rd && reg_addr == `LSIR_ADDR_STAT_B)
    |=> (reg_rdata[7:6] == 2'b00 && reg_rdata[4:0] == 5'b00000
         && reg_rdata[5] == $past(remote_loopback_active)))
    else $error("second status read mismatch");

  cnt_bytes_a: assert property (@(posedge clock) disable iff (srst) // RQ14
    (reg_rd && reg_addr == `LSIR_ADDR_CNT_LOW)
    |=> reg_rdata == $past(mon.err_count[7:0]))
    else $error("counter low byte mismatch");

  cnt_high_a: assert property (@(posedge clock) disable iff (srst) // RQ15
    (reg_rd && reg_addr == `LSIR_ADDR_CNT_HIGH)
    |=> reg_rdata == $past(mon.err_count[15:8]))
    else $error("counter high byte mismatch");

  irq_pending_a: assert property (@(posedge clock) disable iff (srst) // RQ19
    (q.ev_b[3] && !event_mask_b[3]) |-> irq)
    else $error("request low with pending event");

  mask_b_block_a: assert property (@(posedge clock) disable iff (srst) // RQ18
    (event_mask_b[7] && !q.ev_b[7]) |=> !q.ev_b[7])
    else $error("masked second source set its event");

  irq_idle_a: assert property (@(posedge clock) disable iff (srst) // RQ19
    (q.ev_a == 8'h00 && q.ev_b == 8'h00) |-> !irq)
    else $error("request high with no pending event");

endmodule

// ===== design/lsir_err_cnt.sv
// Sixteen bit error counter with overflow pulse.
// Assumes one increment request per clock at most.
`include "lsir_params.svh"

module lsir_err_cnt
  import lsir_pkg::*;
(
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic err_inc,
  lsir_mon_if.cnt   mon
);

  lsir_cnt_s q;
  lsir_cnt_s d;

  // ----------------------------------------------------------------
  // Count and wrap
  // ----------------------------------------------------------------
  always_comb begin
    d     = q;
    d.ovf = err_inc && (q.count == 16'hffff);
    if (err_inc) begin
      d.count = q.count + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q.count <= `LSIR_RST_COUNT;
      q.ovf   <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign mon.err_count = q.count;
  assign mon.cnt_ovf   = q.ovf;

  wrap_ovf_a: assert property (@(posedge clock) disable iff (srst) // RQ13
    (err_inc && q.count == 16'hffff) |=> (mon.cnt_ovf && q.count == 16'h0))
    else $error("counter wrap gave no overflow pulse");

endmodule

// ===== design/lsir_mon_if.sv
// Monitor signals between the register core and its helpers.
// Assumes all ends run on the same clock.
interface lsir_mon_if;
  logic                 tx_line_clock_loss;
  lsir_pkg::lsir_count_t err_count;
  logic                 cnt_ovf;

  modport tmon (output tx_line_clock_loss);
  modport cnt  (output err_count, output cnt_ovf);
  modport core (input tx_line_clock_loss, input err_count, input cnt_ovf);
endinterface

// ===== design/lsir_params.svh
// Constants for the line status and interrupt register group.
// Assumes inclusion by bare name from the core, error counter and clock monitor files.
`ifndef LSIR_PARAMS_SVH
`define LSIR_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LSIR_ADDR_STAT_A    8'h17
`define LSIR_ADDR_STAT_B    8'h18
`define LSIR_ADDR_EVT_A     8'h19
`define LSIR_ADDR_EVT_B     8'h1a
`define LSIR_ADDR_CNT_LOW   8'h1b
`define LSIR_ADDR_CNT_HIGH  8'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LSIR_BIT_LOS        0
`define LSIR_BIT_AIS        1
`define LSIR_BIT_DF         2
`define LSIR_BIT_TX_LINE_CLOCK       3
`define LSIR_BIT_PSYNC      4
`define LSIR_BIT_LB_DEACT   5
`define LSIR_BIT_LB_ACT     6
`define LSIR_BIT_RLOOP      5
`define LSIR_BIT_CNT_OV     0

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define LSIR_RST_BYTE       8'h00
`define LSIR_RST_COUNT      16'h0000
`define LSIR_TX_LINE_CLOCK_LOSS_CYC  7'd70

`endif

// ===== design/lsir_pkg.sv
// Types for the line status and interrupt register group.
// Assumes nothing beyond a SystemVerilog compiler.
package lsir_pkg;

  typedef logic [7:0]  lsir_byte_t;
  typedef logic [6:0]  lsir_src_t;
  typedef logic [15:0] lsir_count_t;

  // ----------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------
  typedef struct packed {
    lsir_src_t  prev;
    lsir_byte_t ev_a;
    lsir_byte_t ev_b;
    lsir_byte_t rdata;
  } lsir_core_s;

  typedef struct packed {
    logic       last;
    logic [6:0] idle;
    logic       loss;
  } lsir_tmon_s;

  typedef struct packed {
    lsir_count_t count;
    logic        ovf;
  } lsir_cnt_s;

endpackage

// ===== design/lsir_tx_line_clock_mon.sv
// Transmit clock loss monitor.
// Assumes the clock pin is already synchronous to the master clock.
`include "lsir_params.svh"

module lsir_tx_line_clock_mon
  import lsir_pkg::*;
(
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic tx_line_clock,
  lsir_mon_if.tmon  mon
);

  lsir_tmon_s q;
  lsir_tmon_s d;
  logic       toggle;

  // ----------------------------------------------------------------
  // Idle count
  // ----------------------------------------------------------------
  assign toggle = tx_line_clock ^ q.last;

  always_comb begin
    d      = q;
    d.last = tx_line_clock;
    if (toggle) begin
      d.idle = 7'd0;
      d.loss = 1'b0;
    end else if (q.idle > `LSIR_TX_LINE_CLOCK_LOSS_CYC) begin
      d.loss = 1'b1; // RQ16
    end else begin
      d.idle = q.idle + 7'd1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign mon.tx_line_clock_loss = q.loss;

  loss_after_idle_a: assert property (@(posedge clock) disable iff (srst) // RQ16
    (!toggle && q.idle > `LSIR_TX_LINE_CLOCK_LOSS_CYC) |=> mon.tx_line_clock_loss)
    else $error("clock loss not flagged after idle period");

  loss_cleared_a: assert property (@(posedge clock) disable iff (srst) // RQ16
    toggle |=> !mon.tx_line_clock_loss)
    else $error("clock loss held despite toggle");

endmodule

// ===== testbench/lsir_core_bench.sv
// Self-checking bench for the line status and interrupt registers.
// Assumes lsir_core as the instantiated DUT with the host model on its read port.
module lsir_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import lsir_pkg::*;

  logic       clock;
  logic       srst;
  lsir_byte_t reg_addr;
  logic       reg_rd;
  lsir_byte_t reg_rdata;
  lsir_src_t  sta;
  logic       remote_loop;
  logic       tx_line_clock;
  logic       tx_line_clock_run;
  lsir_byte_t evb;
  logic       err_inc;
  lsir_src_t  status_mask;
  lsir_src_t  status_edge_sel;
  lsir_byte_t event_mask_b;
  logic       irq;
  int         checks;
  int         bad_count;
  int         sbits[6] = '{0, 1, 2, 4, 5, 6};

  lsir_core dut (
    .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .driver_short_detect(sta[2]),
    .ais_detect(sta[1]), .los_detect(sta[0]),
    .remote_loopback_active(remote_loop), .pattern_sync_detect(sta[4]),
    .loopback_activate_detect(sta[6]), .loopback_deactivate_detect(sta[5]),
    .tx_line_clock(tx_line_clock), .waveform_amp_overflow(evb[7]),
    .jitter_buf_overflow(evb[6]), .jitter_buf_underflow(evb[5]),
    .pattern_error(evb[4]), .excess_zeros(evb[3]),
    .code_violation(evb[2]), .one_second_timer(evb[1]),
    .err_inc(err_inc), .status_mask(status_mask),
    .status_edge_sel(status_edge_sel), .event_mask_b(event_mask_b),
    .irq(irq)
  );

  lsir_host_model host (
    .clock(clock), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  // ----------------------------------------------------------------
  // Clocks
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Run flag sampled on the edge, pin moves 1 ns later
  always @(posedge clock) begin
    if (tx_line_clock_run) tx_line_clock <= #1 ~tx_line_clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input lsir_byte_t seen, input lsir_byte_t exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic expect_reg(input lsir_byte_t addr, input lsir_byte_t exp);
    lsir_byte_t data;
    host.read_reg(addr, data);
    check(data, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1; sta = 7'h00; remote_loop = 1'b0; tx_line_clock = 1'b0;
    tx_line_clock_run = 1'b1; evb = 8'h00; err_inc = 1'b0; status_mask = 7'h00;
    status_edge_sel = 7'h00; event_mask_b = 8'h00; checks = 0;
    bad_count = 0;
    cyc(20);
    srst = 1'b0;
    for (int a = 8'h17; a <= 8'h1c; a++) begin
      expect_reg(8'(a), 8'h00);
    end
    expect_reg(8'h20, 8'h00);
    $display("done: reset values");

    foreach (sbits[i]) begin
      sta = 7'h01 << sbits[i];
      cyc(2);
      expect_reg(8'h17, {1'b0, sta});
      check({7'h00, irq}, 8'h01);
      expect_reg(8'h19, {1'b0, sta});
      check({7'h00, irq}, 8'h00);
      sta = 7'h00;
      cyc(2);
    end
    expect_reg(8'h19, 8'h00);
    remote_loop = 1'b1;
    cyc(2);
    expect_reg(8'h18, 8'h20);
    remote_loop = 1'b0;
    cyc(2);
    expect_reg(8'h18, 8'h00);
    $display("done: live status and rising events");

    status_edge_sel = 7'h7f;
    sta = 7'h77;
    cyc(2);
    expect_reg(8'h19, 8'h77);
    sta = 7'h00;
    cyc(2);
    expect_reg(8'h19, 8'h77);
    status_edge_sel = 7'h00;
    status_mask = 7'h7e;
    sta = 7'h77;
    cyc(2);
    expect_reg(8'h19, 8'h01);
    sta = 7'h00;
    status_mask = 7'h00;
    cyc(2);
    sta = 7'h01;
    cyc(2);
    status_mask = 7'h01;
    cyc(1);
    check({7'h00, irq}, 8'h00);
    status_mask = 7'h00;
    cyc(1);
    check({7'h00, irq}, 8'h01);
    expect_reg(8'h19, 8'h01);
    sta = 7'h00;
    cyc(2);
    $display("done: edge select and masks");

    tx_line_clock_run = 1'b0;
    cyc(60);
    expect_reg(8'h17, 8'h00);
    cyc(20);
    expect_reg(8'h17, 8'h08);
    tx_line_clock_run = 1'b1;
    cyc(4);
    expect_reg(8'h17, 8'h00);
    expect_reg(8'h19, 8'h08);
    $display("done: transmit clock loss");

    for (int b = 1; b < 8; b++) begin
      evb = 8'h01 << b;
      cyc(1);
      evb = 8'h00;
      cyc(2);
      expect_reg(8'h1a, 8'h01 << b);
    end
    expect_reg(8'h1a, 8'h00);
    event_mask_b = 8'hff;
    evb = 8'hfe;
    cyc(1);
    evb = 8'h00;
    cyc(2);
    expect_reg(8'h1a, 8'h00);
    event_mask_b = 8'h00;
    $display("done: second event register");

    err_inc = 1'b1;
    cyc(300);
    err_inc = 1'b0;
    cyc(2);
    expect_reg(8'h1b, 8'h2c);
    expect_reg(8'h1c, 8'h01);
    err_inc = 1'b1;
    cyc(65236);
    err_inc = 1'b0;
    cyc(4);
    expect_reg(8'h1b, 8'h00);
    expect_reg(8'h1c, 8'h00);
    expect_reg(8'h1a, 8'h01);
    $display("done: error counter and overflow");
    report_and_stop();
  end
endmodule

// ===== testbench/lsir_host_model.sv
// Host processor model driving the register read port.
// Assumes the bench calls read_reg; strobes change 1 ns after an edge.
module lsir_host_model (
  input  wire logic                 clock,
  output lsir_pkg::lsir_byte_t      reg_addr,
  output logic                      reg_rd,
  input  wire lsir_pkg::lsir_byte_t reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import lsir_pkg::*;

  initial begin
    reg_addr = 8'h00;
    reg_rd   = 1'b0;
  end

  // One read strobe, data taken the cycle after it is accepted
  task automatic read_reg(input lsir_byte_t addr, output lsir_byte_t data);
    @(posedge clock);
    #1;
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(posedge clock);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~addr;
    data     = reg_rdata;
  endtask
endmodule
